//--- hdl/fsp_pkg.sv
// Constants, register map and state types of the four-mode serial port.
`default_nettype none
package fsp_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_BUF = 8'h04;
  localparam logic [7:0] OFF_ADDR = 8'h08;
  // Control register field positions.
  localparam int unsigned B_RI = 0;
  localparam int unsigned B_TI = 1;
  localparam int unsigned B_RB8 = 2;
  localparam int unsigned B_TB8 = 3;
  localparam int unsigned B_REN = 4;
  localparam int unsigned B_SM2 = 5;
  localparam int unsigned B_MODE = 6;
  localparam int unsigned B_BAUD_DOUBLING_BIT = 8;
  localparam int unsigned B_FE = 9;
  localparam int unsigned B_TSEL = 10;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  // Synchronous mode timing in clocks: period, data lead, clock low time.
  localparam logic [3:0] M0_PER_SLOW = 4'hc;
  localparam logic [3:0] M0_LEAD_SLOW = 4'h3;
  localparam logic [3:0] M0_LOW_SLOW = 4'h6;
  localparam logic [3:0] M0_PER_FAST = 4'h4;
  localparam logic [3:0] M0_LEAD_FAST = 4'h1;
  localparam logic [3:0] M0_LOW_FAST = 4'h2;
  localparam logic [3:0] M0_LAST_BIT = 4'h7;
  // Fixed-rate 16x tick: every 2 clocks (doubling on) or every 4 clocks.
  localparam logic [1:0] OSC_TOP_FAST = 2'h1;
  localparam logic [1:0] OSC_TOP_SLOW = 2'h3;
  localparam logic [3:0] DIV_LAST = 4'hf;
  localparam logic [3:0] SMP_A = 4'h7;
  localparam logic [3:0] SMP_C = 4'h9;
  localparam logic [3:0] BITS_TEN = 4'ha;
  localparam logic [3:0] BITS_ELEVEN = 4'hb;
  typedef enum logic [1:0] {
    MODE_SYNC = 2'b00, MODE_TEN = 2'b01, MODE_FIX = 2'b10, MODE_TMR = 2'b11
  } fsp_mode_t;
  typedef enum logic [1:0] {
    M0_IDLE = 2'b00, M0_TX = 2'b01, M0_RX = 2'b11
  } fsp_m0_t;
  typedef enum logic {
    RX_IDLE = 1'b0, RX_BITS = 1'b1
  } fsp_rx_t;
endpackage
`default_nettype wire

//--- hdl/fsp_serial_port.sv
// Four-mode serial port with an APB register interface.
// Operation
// - Two-bit mode field picks sync 8-bit, async 10-bit, fixed 11-bit, timer 11-bit.
// - Buffer writes load transmit data; buffer reads return the separate receive data.
// - Mode 0 moves eight bits LSB first on data line; device drives shift clock.
// - Mode 0 rate is clock/12 with rate bit 0, clock/4 with it 1.
// - Data leads falling edge 1 clock, low 2; or lead 3, low 6.
// - Mode 0 buffer write shifts eight bits out, then sets transmit-done flag.
// - Mode 0 receive runs while enabled and receive flag clear; peer changes on fall.
// - Mode 0 receive flag set after last rising edge; holds off further reception.
// - Mode 1 frame: start 0, eight data LSB first, stop 1 into ninth flag.
// - Mode 1 bit rate is timer overflow over 16 or 32 by doubling bit.
// - Async transmit starts at first divider rollover after write; one bit per rollover.
// - Mode 1 transmit-done flag set at tenth rollover after the write.
// - Modes 2 and 3 transmit-done flag set at eleventh rollover after the write.
// - Receiver watches line at 16x; falling edge resets the divide-by-16 counter.
// - Each bit is majority of samples at divider states 7, 8 and 9.
// - A start bit sampled as 1 aborts reception and restarts edge search.
// - Frame stored and flag set only if flag clear and multiproc or stop allow.
// - Receiver resumes edge search in the middle of the stop bit.
// - Modes 2/3 frame: start, eight data, ninth bit from control, stop.
// - Mode 2 bit rate is a fixed clock fraction chosen by doubling bit.
// - Mode 3 equals mode 2 but with a timer-derived bit rate.
// - Baud tick may come from either of two timers.
// - Missing stop bit sets a sticky frame error flag cleared only by software.
// - Address match on masked bits, or against broadcast address (address OR mask).
//
// The APB slave port and the placing of the registers are this design's own decisions.
`default_nettype none
module fsp_serial_port (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [fsp_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output var  logic [31:0]                 prdata,
  output var  logic                        pready,
  output var  logic                        pslverr,
  input  wire logic                        baud_tick_t1,
  input  wire logic                        baud_tick_t2,
  input  wire logic                        rxd_in,
  output var  logic                        rxd_out,
  output var  logic                        rxd_oe,
  output var  logic                        txd_out
);
  import fsp_pkg::*;

  function automatic logic maj3(input logic a, input logic b, input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction

  function automatic logic addr_hit(input logic [7:0] rx, input logic [7:0] sa,
                                    input logic [7:0] mk);
    logic [7:0] bc;
    bc = sa | mk;
    return (((rx ^ sa) & mk) == 8'h00) || (((rx ^ bc) & bc) == 8'h00);
  endfunction

  logic        ri_r, ti_r, rb8_r, tb8_r, ren_r, sm2_r, baud_doubling_bit_r, fe_r, tsel_r;
  fsp_mode_t   mode_r;
  logic [7:0]  slave_address_r, smask_r, rbuf_r;
  logic        rx_s1_r, rx_s2_r, rx_prev_r, half_r;
  logic [1:0]  osc_cnt_r;
  logic [3:0]  div_r;
  fsp_rx_t     rx_st_r;
  logic [3:0]  rbit_cnt_r;
  logic [1:0]  smp_r;
  logic [8:0]  rx_sh_r;
  logic        tx_pend_r, tx_busy_r;
  logic [10:0] tx_sh_r;
  logic [3:0]  tx_cnt_r;
  fsp_m0_t     m0_st_r;
  logic [3:0]  ph_r, m0_cnt_r;
  logic [7:0]  m0_sh_r;
  logic [31:0] prdata_nxt;
  logic        err_nxt;

  // APB decode: read data is captured in the setup cycle, so the slave
  // answers with no wait state while every output still comes from a flop.
  wire setup    = psel & ~penable;
  wire access   = psel & penable & pready;
  wire sel_ctrl = paddr == OFF_CTRL;
  wire sel_buf  = paddr == OFF_BUF;
  wire sel_addr = paddr == OFF_ADDR;
  wire wr_ctrl  = access & pwrite & sel_ctrl;
  wire wr_buf   = access & pwrite & sel_buf;
  wire wr_addr  = access & pwrite & sel_addr;
  wire [10:0] ctrl_rd = {tsel_r, fe_r, baud_doubling_bit_r, mode_r, sm2_r, ren_r, tb8_r, rb8_r, ti_r, ri_r};

  always_comb begin
    prdata_nxt = 32'h0000_0000;
    err_nxt = 1'b0;
    if (sel_ctrl) begin
      prdata_nxt = {21'h00_0000, ctrl_rd};
    end else if (sel_buf) begin
      prdata_nxt = {24'h00_0000, rbuf_r};
    end else if (sel_addr) begin
      prdata_nxt = {16'h0000, smask_r, slave_address_r};
    end else begin
      err_nxt = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      prdata  <= setup && !pwrite ? prdata_nxt : 32'h0000_0000;
      pslverr <= setup & err_nxt;
    end
  end

  wire async_m = mode_r != MODE_SYNC;
  wire [3:0] nbits = mode_r == MODE_TEN ? BITS_TEN : BITS_ELEVEN;

  // Baud tick at sixteen times the bit rate.
  wire t_tick   = tsel_r ? baud_tick_t2 : baud_tick_t1;
  wire [1:0] osc_top = baud_doubling_bit_r ? OSC_TOP_FAST : OSC_TOP_SLOW;
  wire osc_tick = osc_cnt_r == osc_top;
  wire tmr_tick = t_tick & (baud_doubling_bit_r | half_r);
  wire tick     = mode_r == MODE_FIX ? osc_tick : tmr_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_cnt_r <= 2'h0;
      half_r    <= 1'b0;
      rx_s1_r   <= 1'b1;
      rx_s2_r   <= 1'b1;
      rx_prev_r <= 1'b1;
    end else begin
      osc_cnt_r <= osc_tick ? 2'h0 : osc_cnt_r + 2'h1;
      half_r    <= t_tick ? ~half_r : half_r;
      rx_s1_r   <= rxd_in;
      rx_s2_r   <= rx_s1_r;
      rx_prev_r <= tick ? rx_s2_r : rx_prev_r;
    end
  end

  // Asynchronous receiver.
  wire rx_idle  = rx_st_r == RX_IDLE;
  wire fall     = tick & rx_prev_r & ~rx_s2_r;
  wire rx_start = async_m & ren_r & rx_idle & fall;
  wire roll     = tick & (div_r == DIV_LAST) & ~rx_start;
  wire in_smp   = (div_r >= SMP_A) && (div_r < SMP_C);
  wire bit_done = tick & ~rx_idle & (div_r == SMP_C);
  wire bit_val  = maj3(smp_r[1], smp_r[0], rx_s2_r);
  wire is_start = rbit_cnt_r == 4'h0;
  wire is_last  = rbit_cnt_r == nbits - 4'h1;
  wire rx_abort = bit_done & is_start & bit_val;
  wire [8:0] frame = mode_r == MODE_TEN ? {bit_val, rx_sh_r[8:1]} : rx_sh_r;
  wire addr_ok  = addr_hit(frame[7:0], slave_address_r, smask_r);
  wire accept   = ~ri_r & (~sm2_r | (frame[8] & addr_ok));
  wire frm_end  = bit_done & is_last;
  wire rx_load  = frm_end & accept;
  wire fe_set   = frm_end & ~bit_val;
  wire do_shift = bit_done & ~is_start & (mode_r == MODE_TEN | ~is_last);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r      <= 4'h0;
      rx_st_r    <= RX_IDLE;
      rbit_cnt_r <= 4'h0;
      smp_r      <= 2'h0;
      rx_sh_r    <= 9'h000;
    end else begin
      if (rx_start) begin
        div_r <= 4'h0;
      end else if (tick) begin
        div_r <= div_r + 4'h1;
      end
      if (tick && in_smp) begin
        smp_r <= {smp_r[0], rx_s2_r};
      end
      if (do_shift) begin
        rx_sh_r <= {bit_val, rx_sh_r[8:1]};
      end
      if (rx_start) begin
        rx_st_r    <= RX_BITS;
        rbit_cnt_r <= 4'h0;
      end else if (rx_abort || frm_end || !async_m) begin
        rx_st_r <= RX_IDLE;
      end else if (bit_done) begin
        rbit_cnt_r <= rbit_cnt_r + 4'h1;
      end
    end
  end

  // Synchronous mode engine; the phase counter spans one shift period.
  wire [3:0] m0_per  = sm2_r ? M0_PER_FAST : M0_PER_SLOW;
  wire [3:0] m0_lead = sm2_r ? M0_LEAD_FAST : M0_LEAD_SLOW;
  // New data goes out at the wrap, so the clock falls lead clocks after it.
  wire [3:0] m0_fall = m0_lead - 4'h1;
  wire [3:0] m0_rise = m0_fall + (sm2_r ? M0_LOW_FAST : M0_LOW_SLOW);
  wire m0_wrap  = ph_r == m0_per - 4'h1;
  wire m0_done  = m0_st_r != M0_IDLE && m0_wrap && m0_cnt_r == M0_LAST_BIT;
  wire m0_go_tx = !async_m && m0_st_r == M0_IDLE && wr_buf;
  wire m0_go_rx = !async_m && m0_st_r == M0_IDLE && !wr_buf && ren_r && !ri_r;
  wire m0_ti    = m0_done && m0_st_r == M0_TX;
  wire m0_ri    = m0_done && m0_st_r == M0_RX;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m0_st_r  <= M0_IDLE;
      ph_r     <= 4'h0;
      m0_cnt_r <= 4'h0;
      m0_sh_r  <= 8'h00;
      rxd_out  <= 1'b1;
      rxd_oe   <= 1'b0;
    end else if (async_m) begin
      m0_st_r <= M0_IDLE;
      rxd_oe  <= 1'b0;
    end else if (m0_go_tx || m0_go_rx) begin
      m0_st_r  <= m0_go_tx ? M0_TX : M0_RX;
      ph_r     <= 4'h0;
      m0_cnt_r <= 4'h0;
      m0_sh_r  <= pwdata[7:0];
      rxd_out  <= pwdata[0];
      rxd_oe   <= m0_go_tx;
    end else if (m0_st_r != M0_IDLE) begin
      ph_r <= m0_wrap ? 4'h0 : ph_r + 4'h1;
      if (m0_st_r == M0_RX && ph_r == m0_rise) begin
        m0_sh_r <= {rx_s2_r, m0_sh_r[7:1]};
      end
      if (m0_done) begin
        m0_st_r <= M0_IDLE;
        rxd_oe  <= 1'b0;
      end else if (m0_wrap) begin
        m0_cnt_r <= m0_cnt_r + 4'h1;
        if (m0_st_r == M0_TX) begin
          m0_sh_r <= {1'b0, m0_sh_r[7:1]};
          rxd_out <= m0_sh_r[1];
        end
      end
    end
  end

  // Asynchronous transmitter paced by divider rollovers; the pin also
  // carries the shift clock in synchronous mode.
  wire tx_last = tx_busy_r && tx_cnt_r == nbits - 4'h1;
  wire a_ti    = roll && tx_last;
  wire ninth   = mode_r == MODE_TEN ? 1'b1 : tb8_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pend_r <= 1'b0;
      tx_busy_r <= 1'b0;
      tx_sh_r   <= 11'h7ff;
      tx_cnt_r  <= 4'h0;
      txd_out   <= 1'b1;
    end else if (!async_m) begin
      tx_pend_r <= 1'b0;
      tx_busy_r <= 1'b0;
      if (m0_st_r == M0_IDLE || m0_done || ph_r == m0_rise) begin
        txd_out <= 1'b1;
      end else if (ph_r == m0_fall) begin
        txd_out <= 1'b0;
      end
    end else begin
      if (wr_buf) begin
        tx_pend_r <= 1'b1;
        tx_sh_r   <= {1'b1, ninth, pwdata[7:0], 1'b0};
      end else if (roll && !tx_busy_r && tx_pend_r) begin
        tx_pend_r <= 1'b0;
      end
      if (roll && tx_busy_r) begin
        txd_out   <= tx_sh_r[tx_cnt_r];
        tx_cnt_r  <= tx_cnt_r + 4'h1;
        tx_busy_r <= !tx_last;
      end else if (roll && tx_pend_r) begin
        txd_out   <= 1'b0;
        tx_cnt_r  <= 4'h1;
        tx_busy_r <= 1'b1;
      end
    end
  end

  // Control and address registers; a hardware set wins over a clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ri_r <= 1'b0;
      ti_r <= 1'b0;
      rb8_r <= 1'b0;
      tb8_r <= 1'b0;
      ren_r <= 1'b0;
      sm2_r <= 1'b0;
      baud_doubling_bit_r <= 1'b0;
      fe_r <= 1'b0;
      tsel_r <= 1'b0;
      mode_r <= MODE_SYNC;
      slave_address_r <= ADDR_RST[7:0];
      smask_r <= ADDR_RST[15:8];
      rbuf_r <= 8'h00;
    end else begin
      ri_r <= rx_load | m0_ri | (wr_ctrl ? pwdata[B_RI] : ri_r);
      ti_r <= a_ti | m0_ti | (wr_ctrl ? pwdata[B_TI] : ti_r);
      fe_r <= fe_set | (wr_ctrl ? pwdata[B_FE] : fe_r);
      if (rx_load) begin
        rb8_r <= frame[8];
      end else if (wr_ctrl) begin
        rb8_r <= pwdata[B_RB8];
      end
      if (rx_load) begin
        rbuf_r <= frame[7:0];
      end else if (m0_ri) begin
        rbuf_r <= m0_sh_r;
      end
      if (wr_ctrl) begin
        tb8_r <= pwdata[B_TB8];
        ren_r <= pwdata[B_REN];
        sm2_r <= pwdata[B_SM2];
        mode_r <= fsp_mode_t'(pwdata[B_MODE+:2]);
        baud_doubling_bit_r <= pwdata[B_BAUD_DOUBLING_BIT];
        tsel_r <= pwdata[B_TSEL];
      end
      if (wr_addr) begin
        slave_address_r <= pwdata[7:0];
        smask_r <= pwdata[15:8];
      end
    end
  end

  default clocking dcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_sync_clk_idle: assert property (!async_m && m0_st_r == M0_IDLE |=> txd_out)
    else $error("Shift clock not high while mode 0 idle.");
  chk_fast_low_time: assert property (
    $fell(txd_out) && !async_m && sm2_r && !wr_ctrl |-> ##1 !txd_out ##1 txd_out)
    else $error("Fast shift clock low time not two clocks.");
  chk_slow_low_time: assert property (
    $fell(txd_out) && !async_m && !sm2_r && !wr_ctrl |-> ##1 !txd_out[*5] ##1 txd_out)
    else $error("Slow shift clock low time not six clocks.");
  chk_rbuf_on_flag: assert property ($changed(rbuf_r) |-> ri_r && !$past(ri_r))
    else $error("Receive buffer changed without raising the receive flag.");
  chk_start_abort: assert property (rx_abort |=> rx_st_r == RX_IDLE && rbit_cnt_r == 4'h0)
    else $error("Invalid start bit did not abort reception.");
  chk_ri_sticky: assert property (ri_r && !wr_ctrl |=> ri_r)
    else $error("Receive flag dropped without a software write.");
  chk_fe_sticky: assert property (fe_r && !wr_ctrl |=> fe_r)
    else $error("Frame error flag dropped without a software write.");
  chk_ti_at_stop: assert property (
    $rose(ti_r) && async_m && !$past(wr_ctrl) |-> $past(roll) && txd_out)
    else $error("Async transmit-done flag not tied to the stop bit rollover.");
  chk_start_on_roll: assert property (
    $fell(txd_out) && async_m && $past(async_m) && $past(!tx_busy_r) |-> $past(roll))
    else $error("Start bit not launched on a divider rollover.");

  cov_sync_tx: cover property (m0_ti);
  cov_sync_rx: cover property (m0_ri);
  cov_async_rx: cover property (rx_load);
  cov_frame_err: cover property (fe_set);
endmodule
`default_nettype wire

//--- tb/four_mode_serial_port_test.sv
// Self-checking testbench of the four-mode serial port.
`default_nettype none
module four_mode_serial_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  import fsp_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, err, t;
  logic        baud_tick_t1, baud_tick_t2, tdiv, t1_on;
  logic        rxd_in, rxd_out, rxd_oe, txd_out, peer_drv;
  logic [7:0]  paddr, d, e, a, mk;
  logic [31:0] pwdata, prdata, rd, c;
  logic [31:0] seed = 32'h00009bce;
  logic [10:0] fr;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          lows;
  assign rxd_in = rxd_oe ? rxd_out : peer_drv;
  fsp_serial_port uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .baud_tick_t1(baud_tick_t1), .baud_tick_t2(baud_tick_t2),
    .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out));
  fsp_peer_model peer (.pclk(pclk), .txd_out(txd_out), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
    .drv(peer_drv));
  initial begin
    {presetn, psel, penable, pwrite, baud_tick_t1, baud_tick_t2, tdiv, t1_on} = 8'h01;
    paddr = 8'h00;
    pwdata = 32'h0;
    forever #2.5 pclk = ~pclk;
  end
  // Timer ticks every second clock; timer one can be silenced to prove the select works.
  always @(posedge pclk) begin
    tdiv <= ~tdiv;
    baud_tick_t1 <= tdiv & t1_on;
    baud_tick_t2 <= tdiv;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [10:0] frame(input logic [7:0] b, input logic n);
    return {1'b1, n, b, 1'b0};
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_flag(input int b);
    rd = 32'h0;
    while (rd[b] !== 1'b1) apb(1'b0, OFF_CTRL, 32'h0);
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge pclk);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("idle pins", 32'h2, {30'h0, txd_out, rxd_oe});
    apb(1'b0, OFF_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b0, OFF_ADDR, 32'h0);
    chk("addr reset", 32'h0, rd);
    apb(1'b1, 8'h0c, 32'hffffffff);
    chk("unmapped error", 32'h1, {31'h0, err});
    for (int r = 0; r < 2; r++) begin
      d = xs();
      apb(1'b1, OFF_CTRL, {26'h0, 1'(r), 5'h0});
      apb(1'b1, OFF_BUF, {24'h0, d});
      wait_flag(B_TI);
      chk("m0 tx byte", {24'h0, d}, {24'h0, peer.m0_rx});
      chk("m0 clock low", (r != 0) ? 32'h2 : 32'h6, {28'h0, peer.last_low});
      apb(1'b0, OFF_CTRL, 32'h0);
      chk("m0 tx flags", {26'h0, 1'(r), 5'h2}, rd);
    end
    e = xs();
    peer.m0_tx = e;
    peer.m0_en = 1'b1;
    apb(1'b1, OFF_CTRL, 32'h10);
    wait_flag(B_RI);
    lows = 0;
    repeat (100) begin
      @(posedge pclk);
      if (!txd_out) lows++;
    end
    chk("m0 rx held off", 32'h0, 32'(lows));
    apb(1'b0, OFF_BUF, 32'h0);
    chk("m0 rx byte", {24'h0, e}, rd);
    peer.m0_en = 1'b0;
    peer.drv <= 1'b1;
    for (int m = 1; m < 4; m++) begin
      d = xs();
      e = xs();
      t = d[0];
      t1_on <= (m != 3);
      c = {21'h0, 1'(m == 3), 2'b01, 2'(m), 2'b01, t, 3'b000};
      apb(1'b1, OFF_CTRL, c);
      fork
        apb(1'b1, OFF_BUF, {24'h0, d});
        peer.get((m == 1) ? 10 : 11, fr);
      join
      chk("async tx frame", {21'h0, frame(d, (m == 1) | t)}, {21'h0, fr});
      // A short low pulse must be taken for a false start and dropped.
      peer.drv <= 1'b0;
      repeat (4) @(posedge pclk);
      peer.drv <= 1'b1;
      repeat (64) @(posedge pclk);
      peer.send(frame(e, (m == 1) | ~t), (m == 1) ? 10 : 11);
      apb(1'b0, OFF_CTRL, 32'h0);
      chk("async flags", c | {29'h0, (m == 1) | ~t, 2'b11}, rd);
      apb(1'b0, OFF_BUF, 32'h0);
      chk("async rx byte", {24'h0, e}, rd);
    end
    t1_on <= 1'b1;
    a = xs() | 8'h01;
    mk = xs() | 8'h01;
    apb(1'b1, OFF_ADDR, {16'h0, mk, a});
    apb(1'b1, OFF_CTRL, 32'h1f0);
    // Only the broadcast frame may land; an earlier load would block it.
    peer.send(frame(a, 1'b0), 11);
    peer.send(frame(a ^ 8'h01, 1'b1), 11);
    peer.send(frame(a | mk, 1'b1), 11);
    apb(1'b0, OFF_BUF, 32'h0);
    chk("address filter", {24'h0, a | mk}, rd);
    apb(1'b1, OFF_CTRL, 32'h150);
    peer.send(frame(a, 1'b0), 10);
    peer.send(frame(mk, 1'b1), 10);
    apb(1'b0, OFF_CTRL, 32'h0);
    chk("frame error flags", 32'h351, rd);
    apb(1'b0, OFF_BUF, 32'h0);
    chk("rx not overwritten", {24'h0, a}, rd);
    tally_and_finish();
  end
endmodule
`default_nettype wire

//--- tb/fsp_peer_model.sv
// Peer serial device on the link side of the four-mode serial port.
`default_nettype none
module fsp_peer_model (
  input  wire logic pclk,
  input  wire logic txd_out,
  input  wire logic rxd_out,
  input  wire logic rxd_oe,
  output var  logic drv
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       m0_en = 1'b0;
  logic [7:0] m0_tx = 8'h00;
  logic [7:0] m0_rx = 8'h00;
  logic [3:0] lowc = 4'h0;
  logic [3:0] last_low = 4'h0;
  logic       txq = 1'b1;
  // The data line has a pull-up, so a released line reads high.
  initial drv = 1'b1;
  // New data goes out on the falling shift clock so it is settled at the rising one.
  always @(negedge txd_out) if (m0_en && !rxd_oe) begin
    drv <= m0_tx[0];
    m0_tx <= {1'b1, m0_tx[7:1]};
  end
  always @(posedge txd_out) if (rxd_oe) m0_rx <= {rxd_out, m0_rx[7:1]};
  // The low time of the last shift-clock pulse is kept for the bench to inspect.
  always @(posedge pclk) begin
    txq <= txd_out;
    lowc <= txd_out ? 4'h0 : lowc + 4'h1;
    if (txd_out && !txq) last_low <= lowc;
  end
  task automatic send(input logic [10:0] f, input int nb);
    for (int i = 0; i < nb; i++) begin
      drv <= f[i];
      repeat (32) @(posedge pclk);
    end
    // Idle high long enough that the next start bit is seen as a fresh edge.
    drv <= 1'b1;
    repeat (16) @(posedge pclk);
  endtask
  // Bits are read mid-cell, 32 clocks apart at the rate the bench sets up.
  task automatic get(input int nb, output logic [10:0] f);
    f = 11'h7ff;
    @(negedge txd_out);
    repeat (16) @(posedge pclk);
    for (int i = 0; i < nb; i++) begin
      f[i] = txd_out;
      repeat (32) @(posedge pclk);
    end
  endtask
endmodule
`default_nettype wire
